/* File: dv/ssm_spi_host.sv */
// behavioural spi and i2c host driving the slave port, msb first
// assumes miso and sda are resolved with pull-ups by the bench
`timescale 1ns/1ps
module ssm_spi_host (
  output logic sck,
  output logic cs_n,
  output logic mosi,
  output logic scl,
  output logic sda_m,
  input wire logic miso,
  input wire logic sda
);
  logic cpol;
  logic cpha;
  initial begin
    cpol = 1'b0;
    cpha = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // ==========================================================
  // one frame: command byte then n data bytes, 800 ns bit time
  // the 130 ns lead keeps link edges off the pclk edges
  task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wd,
      output logic [31:0] rd);
    logic [7:0] tx;
    logic [7:0] rx;
    rd = 32'h0;
    rx = 8'h00;
    sck = cpol;
    #130 cs_n = 1'b0;
    #400;
    for (int b = 0; b <= n; b++) begin
      tx = (b == 0) ? cmd : wd[8 * (b - 1) +: 8];
      for (int i = 7; i >= 0; i--) begin
        if (!cpha)
          mosi = tx[i];
        #400 sck = ~sck;
        if (cpha)
          mosi = tx[i];
        else
          rx[i] = miso;
        #400 sck = ~sck;
        if (cpha)
          rx[i] = miso;
      end
      if (b > 0)
        rd[8 * (b - 1) +: 8] = rx;
    end
    #400 cs_n = 1'b1;
    mosi = ~mosi;
    #800;
  endtask
  // i2c write: start, address, offset, one data byte, stop
  // sda_m only releases or pulls low, so the bench wire behaves open-drain
  task automatic i2c_wr(input logic [7:0] a, input logic [7:0] o, input logic [7:0] wd,
      output logic [2:0] acks);
    logic [23:0] s;
    s = {a, o, wd};
    acks = 3'h0;
    #130 sda_m = 1'b0;
    #400 scl = 1'b0;
    for (int b = 2; b >= 0; b--) begin
      for (int i = 7; i >= 0; i--) begin
        sda_m = s[8 * b + i];
        #400 scl = 1'b1;
        #400 scl = 1'b0;
      end
      sda_m = 1'b1;
      #400 scl = 1'b1;
      acks[b] = ~sda;
      #400 scl = 1'b0;
    end
    sda_m = 1'b0;
    #400 scl = 1'b1;
    #400 sda_m = 1'b1;
    #800;
  endtask
endmodule // ssm_spi_host

/* File: dv/ssm_top_checker.sv */
// port checker for the shared-ram serial slave
// sees only top ports; one pclk domain, bound below
`timescale 1ns/1ps
module ssm_top_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe,
  input wire logic i2c_scl,
  input wire logic i2c_sda_i,
  input wire logic i2c_sda_o,
  input wire logic i2c_sda_oe
);
  // ==========================================================
  // assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel && penable && ce |-> pready)
    else $error("access not answered at once");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_ready_frozen: assert property (!ce |-> !pready)
    else $error("ready while frozen");
  a_err_ready: assert property (pslverr |-> pready && psel)
    else $error("error without ready");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_miso_quiet: assert property (spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  a_sda_open: assert property (!i2c_sda_o)
    else $error("sda driven high");
  a_one_mode: assert property (!(spi_miso_oe && i2c_sda_oe))
    else $error("both serial outputs on");
  a_reset_quiet: assert property ($rose(presetn) |-> !pready && !spi_miso_oe)
    else $error("outputs busy after reset");
endmodule // ssm_top_checker

bind ssm_top ssm_top_checker ssm_top_checker_inst (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
  .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .i2c_scl(i2c_scl),
  .i2c_sda_i(i2c_sda_i), .i2c_sda_o(i2c_sda_o), .i2c_sda_oe(i2c_sda_oe));

/* File: dv/tb.sv */
// self-checking bench: apb master, spi host, byte-level ram model
// assumes miso and sda pulled up; the host model drives both links
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, ce, psel, penable, pwrite, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, flags, d, en;
  logic pready, pslverr, spi_sck, spi_cs_n, spi_mosi, spi_miso_o, spi_miso_oe;
  logic i2c_sda_o, i2c_sda_oe, spi_miso, i2c_sda, i2c_scl, i2c_sda_m;
  logic [2:0] acks;
  int error_cnt, cmp_count, base, limit, host_readonly_base, ptr;
  int ram [256];
  assign spi_miso = spi_miso_oe ? spi_miso_o : 1'b1;
  assign i2c_sda = i2c_sda_oe ? 1'b0 : i2c_sda_m;
  ssm_top ssm_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
    .i2c_scl(i2c_scl), .i2c_sda_i(i2c_sda), .i2c_sda_o(i2c_sda_o), .i2c_sda_oe(i2c_sda_oe));
  ssm_spi_host ssm_spi_host_inst (.sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi),
    .scl(i2c_scl), .sda_m(i2c_sda_m), .miso(spi_miso), .sda(i2c_sda));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ==========================================================
  // reporting and bus tasks
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 40) begin
      chk(1'b0, 1'b1, "apb timeout");
      final_report();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(r, exp, what);
  endtask
  // ==========================================================
  // host side model
  function automatic int flag_of(input int off);
    if (off < 16)
      return 31 - off;
    if (off >= 'h10 && off <= 'h4F && off % 4 == 3)
      return 15 - (off - 'h13) / 4;
    return -1;
  endfunction
  function automatic logic [31:0] prio(input logic [31:0] v);
    for (int i = 31; i >= 0; i--)
      if (v[i])
        return 32'(31 - i);
    return 32'h0;
  endfunction
  task automatic host_wr(input int off, input int n, input logic [31:0] wd);
    logic [31:0] x;
    ssm_spi_host_inst.frame({1'b1, 7'(off)}, n, wd, x);
    for (int b = 0; b < n; b++) begin
      if (off < base * 8 && flag_of(off) >= 0)
        flags[flag_of(off)] = 1'b1;
      if (off < host_readonly_base * 8)
        ram[off] = wd[8 * b +: 8];
      if (off != 127)
        off++;
    end
  endtask
  task automatic host_rd(input int off, input int n, input string what);
    logic [31:0] x;
    logic [31:0] exp;
    exp = 32'h0;
    ssm_spi_host_inst.frame({1'b0, 7'(off)}, n, 32'h0, x);
    for (int b = 0; b < n; b++) begin
      if (off == 127) begin
        exp[8 * b +: 8] = 8'(ram[ptr]);
        ptr = (ptr + 1 >= limit * 8) ? base * 8 : ptr + 1;
      end else if (off < base * 8)
        exp[8 * b +: 8] = 8'(ram[off]);
      if (off != 127)
        off++;
    end
    chk(x, exp, what);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, flags} = '0;
    ce = 1'b1;
    {error_cnt, cmp_count} = '0;
    {base, limit, host_readonly_base, ptr} = {32'd16, 32'd32, 32'd10, 32'd128};
    foreach (ram[i]) ram[i] = 0;
    void'($urandom(60));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(ssm_pkg::OFF_STREAM_CFG, 32'h000A2010, "cfg reset");
    rd(ssm_pkg::OFF_STREAM_PTR, 32'h00000080, "ptr reset");
    apb(1'b1, 12'h400, 32'h0000005A);
    apb(1'b1, 12'h000, 32'h00000003);
    rd(12'h400, 32'h0, "ram while disabled");
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h000, 32'h3 | 32'(m << 2));
      ssm_spi_host_inst.cpol = m[0];
      ssm_spi_host_inst.cpha = m[1];
      d = 32'($urandom_range(255, 0));
      host_wr(m, 1, d);
      rd(12'h400 + 12'(4 * m), d, "ram by apb");
      host_rd(m, 1, "readback");
      rd(ssm_pkg::OFF_IRQ_CLEAR, flags, "flags");
    end
    $display("test modes done");
    host_wr('h10, 4, $urandom());
    host_wr('h4F, 1, $urandom());
    rd(ssm_pkg::OFF_IRQ_CLEAR, flags, "word flags");
    host_rd('h10, 4, "burst readback");
    apb(1'b1, 12'h540, 32'h000000C3);
    ram['h50] = 'hC3;
    host_wr('h50, 1, 32'h3C);
    host_rd('h50, 1, "read-only tail");
    $display("test direct done");
    en = $urandom() | 32'h1;
    apb(1'b1, ssm_pkg::OFF_IRQ_ENABLE, en);
    rd(ssm_pkg::OFF_IRQ_STATUS, flags & en, "shown status");
    rd(ssm_pkg::OFF_IRQ_PRIO, prio(flags & en), "priority");
    apb(1'b1, ssm_pkg::OFF_IRQ_CLEAR, 32'hFFFFFFFF);
    flags = 32'h0;
    rd(ssm_pkg::OFF_IRQ_STATUS, 32'h0, "cleared");
    $display("test flags done");
    // software keeps the read-only base at 0x0A
    apb(1'b1, ssm_pkg::OFF_STREAM_CFG, 32'h000A3F0E);
    rd(ssm_pkg::OFF_STREAM_CFG, 32'h000A200E, "limit saturates");
    apb(1'b1, ssm_pkg::OFF_STREAM_CFG, 32'h000A110E);
    {base, limit} = {32'd14, 32'd17};
    for (int i = 'h70; i < 'h88; i++) begin
      d = 32'($urandom_range(255, 1));
      apb(1'b1, 12'h400 + 12'(4 * i), d);
      ram[i] = d;
    end
    apb(1'b1, ssm_pkg::OFF_STREAM_PTR, 32'h00000086);
    ptr = 'h86;
    host_rd(127, 4, "stream wrap");
    rd(ssm_pkg::OFF_STREAM_PTR, 32'(ptr), "ptr after");
    host_rd('h70, 1, "stream not direct");
    $display("test stream done");
    apb(1'b1, ssm_pkg::OFF_I2C_ADDR, 32'h00000052);
    apb(1'b1, ssm_pkg::OFF_CTRL, 32'h00000001);
    d = 32'($urandom_range(255, 0));
    ssm_spi_host_inst.i2c_wr(8'hA4, 8'h23, d[7:0], acks);
    chk(32'(acks), 32'h7, "i2c acks");
    ram['h23] = d;
    flags[flag_of('h23)] = 1'b1;
    rd(12'h48C, d, "i2c write");
    rd(ssm_pkg::OFF_IRQ_CLEAR, flags, "i2c flag");
    $display("test i2c done");
    fork
      apb(1'b0, 12'h020, 32'h0);
      begin
        repeat (2) @(posedge pclk);
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    $display("test refusal done");
    final_report();
  end
endmodule // tb

/* File: verilog/ssm_pkg.sv */
// shared constants and types for the serial slave shared-ram mailbox
// assumes a single 10 MHz apb clock domain; link pins are sampled in it
package ssm_pkg;

  // ==========================================================
  // memory geometry
  localparam int RAM_BYTES = 256;
  localparam logic [6:0] STREAM_OFFSET = 7'h7F;
  localparam logic [6:0] TRIG_WORD_FIRST = 7'h10;
  localparam logic [6:0] TRIG_WORD_LAST = 7'h4F;
  localparam logic [4:0] TRIG_WORD_BASE = 5'h04;
  localparam logic [5:0] STREAM_LIMIT_MAX = 6'h20;

  // ==========================================================
  // apb byte addresses
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_I2C_ADDR = 12'h004;
  localparam logic [11:0] OFF_STREAM_CFG = 12'h008;
  localparam logic [11:0] OFF_STREAM_PTR = 12'h00C;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h010;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h014;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h018;
  localparam logic [11:0] OFF_IRQ_PRIO = 12'h01C;
  localparam logic [1:0] RAM_WINDOW_SEL = 2'h1;

  // ==========================================================
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SPI_BIT = 1;
  localparam int CTRL_CPOL_BIT = 2;
  localparam int CTRL_CPHA_BIT = 3;
  localparam int CTRL_TEN_BIT = 4;
  localparam int CFG_BASE_LSB = 0;
  localparam int CFG_LIMIT_LSB = 8;
  localparam int CFG_HOST_READONLY_BASE_LSB = 16;

  // ==========================================================
  // reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [9:0] I2C_ADDR_RST = 10'h000;
  localparam logic [4:0] STREAM_BASE_RST = 5'h10;
  localparam logic [5:0] STREAM_LIMIT_RST = 6'h20;
  localparam logic [4:0] READONLY_BASE_RST = 5'h0A;
  localparam logic [7:0] STREAM_PTR_RST = 8'h80;
  localparam logic [4:0] PIN_IDLE = 5'h0B;

  // ==========================================================
  // types
  typedef struct packed {
    logic valid;
    logic wr;
    logic [6:0] off;
    logic [7:0] data;
  } ssm_hacc_t;

  typedef struct packed {
    logic [4:0] host_readonly_base;
    logic [5:0] limit;
    logic [4:0] base;
  } ssm_cfg_t;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR_HI,
    I2C_ADDR_LO,
    I2C_OFFSET,
    I2C_WRITE,
    I2C_READ
  } ssm_i2c_state_t;

endpackage

/* File: verilog/ssm_top.sv */
// serial slave port with shared 256-byte ram, stream region and access flags
// assumes apb master on pclk; spi/i2c pins come asynchronously from a host
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module ssm_top #(
  parameter int RAM_BYTES = 256
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  input wire logic i2c_scl,
  input wire logic i2c_sda_i,
  output logic i2c_sda_o,
  output logic i2c_sda_oe
);

  // offset fields are sized for exactly this ram
  if (RAM_BYTES != ssm_pkg::RAM_BYTES) begin : g_bad_size
    $error("ssm_top: RAM_BYTES must be 256");
  end

  // ==========================================================
  // pin synchronisers
  logic [4:0] pin_in;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] prev_q;
  assign pin_in = {spi_sck, spi_cs_n, spi_mosi, i2c_scl, i2c_sda_i};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= ssm_pkg::PIN_IDLE;
      sync2_q <= ssm_pkg::PIN_IDLE;
      prev_q <= ssm_pkg::PIN_IDLE;
    end else if (ce) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  wire sck_rise = sync2_q[4] & ~prev_q[4];
  wire sck_fall = ~sync2_q[4] & prev_q[4];
  wire cs_n = sync2_q[3];
  wire mosi = sync2_q[2];
  wire scl = sync2_q[1];
  wire sda = sync2_q[0];
  wire scl_rise = scl & ~prev_q[1];
  wire scl_fall = ~scl & prev_q[1];
  wire i2c_start = scl & prev_q[1] & ~sda & prev_q[0];
  wire i2c_stop = scl & prev_q[1] & sda & ~prev_q[0];

  // ==========================================================
  // configuration state
  logic [4:0] ctrl_q;
  logic [9:0] i2c_addr_q;
  ssm_pkg::ssm_cfg_t cfg_q;
  logic [7:0] ptr_q;
  logic [31:0] irq_en_q;
  logic [31:0] flags_q;
  logic [4:0] prio_q;
  logic [7:0] ram_q [RAM_BYTES];

  wire en = ctrl_q[ssm_pkg::CTRL_EN_BIT];
  wire spi_mode = ctrl_q[ssm_pkg::CTRL_SPI_BIT];
  wire cpol = ctrl_q[ssm_pkg::CTRL_CPOL_BIT];
  wire cpha = ctrl_q[ssm_pkg::CTRL_CPHA_BIT];
  wire ten_bit = ctrl_q[ssm_pkg::CTRL_TEN_BIT];

  wire [7:0] direct_end = {cfg_q.base, 3'h0};
  wire [7:0] ro_start = {cfg_q.host_readonly_base, 3'h0};
  wire [8:0] stream_end = {cfg_q.limit, 3'h0};

  // ==========================================================
  // host access arbitration between the two serial engines
  ssm_pkg::ssm_hacc_t spi_acc;
  ssm_pkg::ssm_hacc_t i2c_acc;
  ssm_pkg::ssm_hacc_t acc;
  logic [6:0] spi_look;
  logic [6:0] i2c_off_q;
  assign acc = spi_mode ? spi_acc : i2c_acc;

  wire [6:0] look_off = spi_mode ? spi_look : i2c_off_q;
  // direct offsets map straight onto ram
  wire look_direct = {1'b0, look_off} < direct_end;
  // only direct bytes and the stream port are visible
  wire [7:0] host_rd_byte = (look_off == ssm_pkg::STREAM_OFFSET) ? ram_q[ptr_q] :
                            look_direct ? ram_q[{1'b0, look_off}] : 8'h00;

  wire host_wr = acc.valid & acc.wr & en;
  wire host_direct = {1'b0, acc.off} < direct_end;
  wire host_ram_wr = host_wr & host_direct & ({1'b0, acc.off} < ro_start);
  wire stream_rd = acc.valid & ~acc.wr & en & (acc.off == ssm_pkg::STREAM_OFFSET);

  // advance with wrap to the base at the limit
  wire [8:0] ptr_inc = {1'b0, ptr_q} + 9'h001;
  wire [7:0] ptr_next = (ptr_inc >= stream_end) ? direct_end : ptr_inc[7:0];

  // low offsets map to flags 31..16
  wire trig_low = (acc.off[6:4] == 3'h0);
  // last byte of each word up to 0x4F
  wire trig_word = (acc.off >= ssm_pkg::TRIG_WORD_FIRST) &
                   (acc.off <= ssm_pkg::TRIG_WORD_LAST) & (acc.off[1:0] == 2'h3);
  wire [4:0] word_idx = acc.off[6:2] - ssm_pkg::TRIG_WORD_BASE;
  wire [31:0] flag_set = ~(host_wr & host_direct) ? 32'h0000_0000 :
                         trig_low ? (32'h8000_0000 >> acc.off[3:0]) :
                         trig_word ? (32'h0000_8000 >> word_idx[3:0]) : 32'h0000_0000;

  // ==========================================================
  // apb slave
  logic rdy_q;
  logic [31:0] prdata_q;
  wire apb_fire = psel & penable & pready;
  wire apb_wr = apb_fire & pwrite;
  wire is_ram = (paddr[11:10] == ssm_pkg::RAM_WINDOW_SEL) & (paddr[1:0] == 2'h0);
  wire [7:0] ram_idx = paddr[9:2];
  wire hit_ctrl = paddr == ssm_pkg::OFF_CTRL;
  wire hit_addr = paddr == ssm_pkg::OFF_I2C_ADDR;
  wire hit_cfg = paddr == ssm_pkg::OFF_STREAM_CFG;
  wire hit_ptr = paddr == ssm_pkg::OFF_STREAM_PTR;
  wire hit_en = paddr == ssm_pkg::OFF_IRQ_ENABLE;
  wire hit_stat = paddr == ssm_pkg::OFF_IRQ_STATUS;
  wire hit_clr = paddr == ssm_pkg::OFF_IRQ_CLEAR;
  wire hit_prio = paddr == ssm_pkg::OFF_IRQ_PRIO;
  wire mapped = is_ram | hit_ctrl | hit_addr | hit_cfg | hit_ptr | hit_en | hit_stat |
                hit_clr | hit_prio;
  wire apb_ram_wr = apb_wr & is_ram & en;
  // shown only when enabled and set
  wire [31:0] shown = flags_q & irq_en_q;
  wire [31:0] cfg_word = {11'h000, cfg_q.host_readonly_base, 2'h0, cfg_q.limit, 3'h0, cfg_q.base};
  wire [31:0] rd_mux = hit_ctrl ? {27'h0000000, ctrl_q} :
                       hit_addr ? {22'h000000, i2c_addr_q} :
                       hit_cfg ? cfg_word :
                       hit_ptr ? {24'h000000, ptr_q} :
                       hit_en ? irq_en_q :
                       hit_stat ? shown :
                       hit_clr ? flags_q :
                       hit_prio ? {27'h0000000, prio_q} :
                       (is_ram & en) ? {24'h000000, ram_q[ram_idx]} : 32'h0000_0000;
  // zero wait: data latched in setup, answered in the first access cycle
  assign pready = penable & rdy_q & ce;
  assign pslverr = pready & ~mapped;
  assign prdata = prdata_q;

  wire [5:0] limit_wr = pwdata[ssm_pkg::CFG_LIMIT_LSB +: 6];
  wire [31:0] flag_clr = (apb_wr & hit_clr) ? pwdata : 32'h0000_0000;

  // ascending scan lets the highest index win
  function automatic logic [4:0] ssm_prio(input logic [31:0] v);
    logic [4:0] code;
    code = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        code = 5'(31 - i);
      end
    end
    return code;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      ctrl_q <= ssm_pkg::CTRL_RST;
      i2c_addr_q <= ssm_pkg::I2C_ADDR_RST;
      cfg_q <= {ssm_pkg::READONLY_BASE_RST, ssm_pkg::STREAM_LIMIT_RST, ssm_pkg::STREAM_BASE_RST};
      irq_en_q <= 32'h0000_0000;
      flags_q <= 32'h0000_0000;
      prio_q <= 5'h00;
    end else if (ce) begin
      rdy_q <= psel & ~apb_fire;
      if (psel & ~apb_fire) begin
        prdata_q <= rd_mux;
      end
      if (apb_wr & hit_ctrl) begin
        ctrl_q <= pwdata[4:0];
      end
      if (apb_wr & hit_addr) begin
        i2c_addr_q <= pwdata[9:0];
      end
      if (apb_wr & hit_cfg) begin
        cfg_q.base <= pwdata[ssm_pkg::CFG_BASE_LSB +: 5];
        cfg_q.host_readonly_base <= pwdata[ssm_pkg::CFG_HOST_READONLY_BASE_LSB +: 5];
        cfg_q.limit <= (limit_wr > ssm_pkg::STREAM_LIMIT_MAX) ? ssm_pkg::STREAM_LIMIT_MAX : limit_wr;
      end
      if (apb_wr & hit_en) begin
        irq_en_q <= pwdata;
      end
      // set beats a simultaneous clear
      flags_q <= (flags_q & ~flag_clr) | flag_set;
      prio_q <= ssm_prio(shown);
    end
  end

  // software reposition of the pointer wins over a host advance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= ssm_pkg::STREAM_PTR_RST;
    end else if (ce) begin
      if (apb_wr & hit_ptr) begin
        ptr_q <= pwdata[7:0];
      end else if (stream_rd) begin
        ptr_q <= ptr_next;
      end
    end
  end

  // one writer mux per ram byte, host first
  for (genvar g = 0; g < RAM_BYTES; g++) begin : g_ram
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ram_q[g] <= 8'h00;
      end else if (ce) begin
        if (host_ram_wr && ({1'b0, acc.off} == 8'(g))) begin
          ram_q[g] <= acc.data;
        end else if (apb_ram_wr && (ram_idx == 8'(g))) begin
          ram_q[g] <= pwdata[7:0];
        end
      end
    end
  end

  // ==========================================================
  // spi engine: first byte is {write, offset}, then data
  logic [2:0] spi_cnt_q;
  logic spi_first_q;
  logic spi_wr_q;
  logic [6:0] spi_off_q;
  logic [7:0] spi_rx_q;
  logic [7:0] spi_tx_q;
  logic spi_miso_q;
  wire spi_on = en & spi_mode & ~cs_n;
  // sample on the leading edge when phase is zero
  wire spi_samp = spi_on & ((cpol == cpha) ? sck_rise : sck_fall);
  wire [7:0] spi_rx_new = {spi_rx_q[6:0], mosi};
  // offset holds at the stream port
  wire [6:0] spi_off_step = (spi_off_q == ssm_pkg::STREAM_OFFSET) ? spi_off_q : spi_off_q + 7'h01;
  assign spi_look = spi_first_q ? spi_rx_new[6:0] : spi_off_q;
  // a read byte is committed once its first bit is clocked, so no over-fetch
  assign spi_acc.valid = spi_samp & ~spi_first_q &
                         (spi_wr_q ? (spi_cnt_q == 3'h7) : (spi_cnt_q == 3'h0));
  assign spi_acc.wr = spi_wr_q;
  assign spi_acc.off = spi_off_q;
  assign spi_acc.data = spi_rx_new;
  assign spi_miso_o = spi_miso_q;
  assign spi_miso_oe = spi_on;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_cnt_q <= 3'h0;
      spi_first_q <= 1'b1;
      spi_wr_q <= 1'b0;
      spi_off_q <= 7'h00;
      spi_rx_q <= 8'h00;
      spi_tx_q <= 8'h00;
      spi_miso_q <= 1'b0;
    end else if (ce) begin
      if (!spi_on) begin
        spi_cnt_q <= 3'h0;
        spi_first_q <= 1'b1;
        spi_miso_q <= 1'b0;
      end else if (spi_samp) begin
        spi_cnt_q <= spi_cnt_q + 3'h1;
        spi_rx_q <= spi_rx_new;
        if (spi_acc.valid) begin
          spi_off_q <= spi_off_step;
        end
        if (spi_cnt_q == 3'h7) begin
          if (spi_first_q) begin
            spi_first_q <= 1'b0;
            spi_wr_q <= spi_rx_new[7];
            spi_off_q <= spi_rx_new[6:0];
          end
          spi_tx_q <= {host_rd_byte[6:0], 1'b0};
          spi_miso_q <= host_rd_byte[7] & ~(spi_first_q ? spi_rx_new[7] : spi_wr_q);
        end else begin
          spi_tx_q <= {spi_tx_q[6:0], 1'b0};
          spi_miso_q <= spi_tx_q[7];
        end
      end
    end
  end

  // ==========================================================
  // i2c engine: address, offset byte, then data; reads from held offset
  ssm_pkg::ssm_i2c_state_t i2c_st_q;
  ssm_pkg::ssm_i2c_state_t i2c_nst;
  logic [3:0] i2c_cnt_q;
  logic [7:0] i2c_rx_q;
  logic [7:0] i2c_tx_q;
  logic i2c_m10_q;
  logic i2c_oe_q;
  logic i2c_ack;
  wire i2c_on = en & ~spi_mode;
  wire i2c_byte_end = scl_fall & (i2c_cnt_q == 4'h7);
  wire i2c_ack_end = scl_fall & (i2c_cnt_q == 4'h8);
  wire [6:0] i2c_off_step = (i2c_off_q == ssm_pkg::STREAM_OFFSET) ? i2c_off_q : i2c_off_q + 7'h01;
  wire [6:0] hi_pattern = {5'h1E, i2c_addr_q[9:8]};

  always_comb begin
    i2c_nst = i2c_st_q;
    i2c_ack = 1'b0;
    unique case (i2c_st_q)
      ssm_pkg::I2C_IDLE: begin
        i2c_nst = ssm_pkg::I2C_IDLE;
      end
      ssm_pkg::I2C_ADDR_HI: begin
        if (ten_bit) begin
          i2c_ack = (i2c_rx_q[7:1] == hi_pattern) & (~i2c_rx_q[0] | i2c_m10_q);
          i2c_nst = i2c_rx_q[0] ? ssm_pkg::I2C_READ : ssm_pkg::I2C_ADDR_LO;
        end else begin
          i2c_ack = i2c_rx_q[7:1] == i2c_addr_q[6:0];
          i2c_nst = i2c_rx_q[0] ? ssm_pkg::I2C_READ : ssm_pkg::I2C_OFFSET;
        end
      end
      ssm_pkg::I2C_ADDR_LO: begin
        i2c_ack = i2c_rx_q == i2c_addr_q[7:0];
        i2c_nst = ssm_pkg::I2C_OFFSET;
      end
      ssm_pkg::I2C_OFFSET, ssm_pkg::I2C_WRITE: begin
        i2c_ack = 1'b1;
        i2c_nst = ssm_pkg::I2C_WRITE;
      end
      ssm_pkg::I2C_READ: begin
        i2c_ack = 1'b1;
        i2c_nst = ssm_pkg::I2C_READ;
      end
    endcase
  end

  assign i2c_acc.valid = i2c_on & (i2c_st_q == ssm_pkg::I2C_WRITE ? i2c_byte_end :
                                   i2c_st_q == ssm_pkg::I2C_READ ? i2c_ack_end : 1'b0);
  assign i2c_acc.wr = i2c_st_q == ssm_pkg::I2C_WRITE;
  assign i2c_acc.off = i2c_off_q;
  assign i2c_acc.data = i2c_rx_q;
  assign i2c_sda_o = 1'b0;
  assign i2c_sda_oe = i2c_oe_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i2c_st_q <= ssm_pkg::I2C_IDLE;
      i2c_cnt_q <= 4'h0;
      i2c_rx_q <= 8'h00;
      i2c_tx_q <= 8'h00;
      i2c_off_q <= 7'h00;
      i2c_m10_q <= 1'b0;
      i2c_oe_q <= 1'b0;
    end else if (ce) begin
      if (!i2c_on || i2c_stop) begin
        i2c_st_q <= ssm_pkg::I2C_IDLE;
        i2c_m10_q <= 1'b0;
        i2c_oe_q <= 1'b0;
      end else if (i2c_start) begin
        // repeated start keeps the 10-bit match for a read
        i2c_st_q <= ssm_pkg::I2C_ADDR_HI;
        // the scl fall after start carries no bit; it wraps this to zero
        i2c_cnt_q <= 4'hF;
        i2c_oe_q <= 1'b0;
      end else if (i2c_st_q != ssm_pkg::I2C_IDLE) begin
        if (scl_rise && i2c_cnt_q < 4'h8) begin
          i2c_rx_q <= {i2c_rx_q[6:0], sda};
        end else if (scl_rise && i2c_st_q == ssm_pkg::I2C_READ && sda) begin
          // master nack ends the read
          i2c_st_q <= ssm_pkg::I2C_IDLE;
        end
        if (scl_fall) begin
          i2c_cnt_q <= (i2c_cnt_q == 4'h8) ? 4'h0 : i2c_cnt_q + 4'h1;
        end
        if (i2c_byte_end) begin
          i2c_oe_q <= i2c_ack & (i2c_st_q != ssm_pkg::I2C_READ);
          i2c_st_q <= i2c_ack ? i2c_nst : ssm_pkg::I2C_IDLE;
          if (i2c_st_q == ssm_pkg::I2C_ADDR_LO) begin
            i2c_m10_q <= i2c_ack;
          end
          if (i2c_st_q == ssm_pkg::I2C_OFFSET) begin
            i2c_off_q <= i2c_rx_q[6:0];
          end
        end else if (i2c_ack_end) begin
          i2c_tx_q <= {host_rd_byte[6:0], 1'b0};
          i2c_oe_q <= (i2c_st_q == ssm_pkg::I2C_READ) & ~host_rd_byte[7];
        end else if (scl_fall) begin
          i2c_tx_q <= {i2c_tx_q[6:0], 1'b0};
          i2c_oe_q <= (i2c_st_q == ssm_pkg::I2C_READ) & ~i2c_tx_q[7];
        end
        // offset steps except at the stream port
        if (i2c_acc.valid) begin
          i2c_off_q <= i2c_off_step;
        end
      end
    end
  end

endmodule // ssm_top
